// file: core/dac_ctl_pkg.sv
/*
  Shared constants for the serial DAC / reference / temperature control block.
  Assumes a single 200 MHz clock domain and an SPI-style host on the pins.
*/
package dac_ctl_pkg;
  localparam int          DAC_BITS      = 10;
  localparam int          DAC_CHANNELS  = 4;
  localparam int          TEMP_BITS     = 12;
  localparam int          WORD_BITS     = 16;
  localparam int          GPIO_BITS     = 4;
  localparam logic [7:0]  SETUP_RESET   = 8'h28;
  localparam logic [3:0]  CMD_DAC       = 4'h1;
  localparam logic [1:0]  CMD_SETUP     = 2'h1;
  localparam logic [7:0]  CMD_GPIO_WR   = 8'h03;
  localparam int          CMD_CONV_BIT  = 7;
  localparam int          CMD_TEMP_BIT  = 0;
  localparam int          SETUP_CLK_LSB = 4;
  localparam int          SETUP_REF_LSB = 2;
  localparam logic [1:0]  CLK_SCLK      = 2'h3;
  localparam logic [1:0]  REF_INT_BOTH  = 2'h0;
  localparam logic [1:0]  REF_EXT_BOTH  = 2'h1;
  localparam logic [1:0]  REF_ADC_INT   = 2'h2;
  localparam logic [1:0]  REF_DIFF      = 2'h3;
  localparam int          DAC_OP_MSB    = 15;
  localparam int          DAC_OP_LSB    = 12;
  localparam int          DAC_DATA_MSB  = 11;
  localparam int          DAC_DATA_LSB  = 2;
  localparam int          DAC_OP_ALL    = 3;
  localparam int          DAC_OP_LOAD   = 2;
  localparam logic [3:0]  TEMP_PAD      = 4'h0;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [3:0]  OUT_LAST      = 4'hf;
endpackage

// file: core/frame_if.sv
/*
  Interface carrying decoded serial-frame events from the pin shifter to the
  command logic. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface frame_if;
  logic       frame_active;
  logic       frame_start;
  logic       fall_tick;
  logic       byte_valid;
  logic [7:0] rx_byte;

  modport src (output frame_active, output frame_start, output fall_tick,
               output byte_valid, output rx_byte);
  modport dst (input frame_active, input frame_start, input fall_tick,
               input byte_valid, input rx_byte);
endinterface

// file: core/serial_shifter.sv
/*
  Pin synchronisers, serial clock edge detection and byte assembly.
  Assumes the serial clock is at most a quarter of clk so each phase is seen.
*/
`timescale 1ns/1ps
module serial_shifter
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n_pin,
  input  wire logic sclk_pin,
  input  wire logic din_pin,
  frame_if.src      link
);
  logic       cs_s1;
  logic       cs_s2;
  logic       cs_q;
  logic       sclk_s1;
  logic       sclk_s2;
  logic       sclk_q;
  logic       din_s1;
  logic       din_s2;
  logic [2:0] bit_cnt;
  logic [6:0] shreg;

  // Sync stages carry no reset so they track pins while reset is held
  always_ff @(posedge clk)
  begin
    cs_s1   <= cs_n_pin;
    cs_s2   <= cs_s1;
    sclk_s1 <= sclk_pin;
    sclk_s2 <= sclk_s1;
    din_s1  <= din_pin;
    din_s2  <= din_s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      cs_q   <= cs_s2;
      sclk_q <= sclk_s2;
    end
  end

  assign link.frame_active = ~cs_s2;
  assign link.frame_start  = cs_q & ~cs_s2;
  assign link.fall_tick    = ~cs_s2 & sclk_q & ~sclk_s2;

  // Din taken on the falling serial edge, MSB first
  always_ff @(posedge clk)
  begin
    if (!rst_n || cs_s2)
    begin
      bit_cnt         <= '0;
      shreg           <= '0;
      link.byte_valid <= 1'b0;
      link.rx_byte    <= '0;
    end
    else
    begin
      link.byte_valid <= 1'b0;
      if (link.fall_tick)
      begin
        shreg   <= {shreg[5:0], din_s2};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == dac_ctl_pkg::BIT_LAST)
        begin
          link.byte_valid <= 1'b1;
          link.rx_byte    <= {shreg, din_s2};
        end
      end
    end
  end
endmodule

// file: core/dac_bank.sv
/*
  Four double-buffered DAC channels: input registers and output-code registers.
  Assumes wake_level is already synchronised and stable through reset.
*/
`timescale 1ns/1ps
module dac_bank
#(
  parameter int CHANNELS = dac_ctl_pkg::DAC_CHANNELS,
  parameter int BITS     = dac_ctl_pkg::DAC_BITS
)
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           wake_level,
  input  wire logic                           wr_en,
  input  wire logic [$clog2(CHANNELS)-1:0]    wr_chan,
  input  wire logic [BITS-1:0]                wr_data,
  input  wire logic [CHANNELS-1:0]            load_mask,
  output logic      [CHANNELS-1:0][BITS-1:0]  input_code,
  output logic      [CHANNELS-1:0][BITS-1:0]  output_code,
  output logic      [CHANNELS-1:0]            buffer_on
);
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (!rst_n)
      begin
        input_code[i]  <= {BITS{wake_level}};
        output_code[i] <= {BITS{wake_level}};
        buffer_on[i]   <= 1'b0;
      end
      else
      begin
        if (wr_en && wr_chan == i[$clog2(CHANNELS)-1:0])
          input_code[i] <= wr_data;
        // A write and load in one cycle loads the freshly written code
        if (load_mask[i])
        begin
          output_code[i] <= (wr_en && wr_chan == i[$clog2(CHANNELS)-1:0]) ? wr_data : input_code[i];
          buffer_on[i]   <= 1'b1;
        end
      end
    end
  end
endmodule

// file: core/dac_ref_temp_serial_control.sv
/*
  Serial command control: DAC writes and loads, setup register with clock and
  reference modes, GPIO writes, temperature request sequencing and result readout.
  Assumes the ADC core, result FIFO and temperature sensor are outside and
  answer through the scan, temperature and adc_word ports.
*/
// Contract
// - DAC write is command 0001xxxx followed by two bytes of channel and data
// - Chip select low opens a frame; din sampled on falling serial clock
// - Serial words deserialised to parallel data, serial clock up to 25 MHz
// - Each channel has an input register and a 10-bit output-code register
// - Output codes load from input registers on load strobe low or command
// - DAC codes are unipolar straight binary, step is reference over 1024
// - Wake select low: codes start at zero, buffers off, outputs to ground
// - Wake select high: codes start full scale, buffers off, outputs to reference
// - GPIO write is a command byte then one data byte driving four pins
// - Internal oscillator enabled in clock modes 00, 01 and 10
// - Clock mode 11 times conversions from serial clock, 0.1 to 4.8 MHz
// - Results readable at serial clock up to 25 MHz in internal modes
// - Reference select 00 gives internal reference to ADC and DAC
// - Reference select 10: ADC internal, DAC external on first reference pin
// - Reference select 01: DAC on first reference pin, ADC on second
// - Reference select 11: ADC differential, first pin positive, second negative
// - Second reference pin is analog input for 00 and 10, negative otherwise
// - Temperature requested by conversion command byte with bit 0 set
// - Temperature converts before channels and is read as first two bytes
// - Temperature result is two's complement Celsius, eighth degree per step
// - A new temperature result overwrites an unread previous one
// - Temperature conversions always use the internal reference
// - GPIO command and data bytes ignored on variants without GPIO
// - Setup register resets to 0010 1000
// - DAC input registers reset to full scale or zero by wake select
// - Setup command has bit 7 zero, bit 6 one, clock 5:4, reference 3:2
`timescale 1ns/1ps
module dac_ref_temp_serial_control
#(
  parameter bit HAS_GPIO = 1'b1,
  parameter int CHANNELS = dac_ctl_pkg::DAC_CHANNELS,
  parameter int DAC_BITS = dac_ctl_pkg::DAC_BITS
)
(
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   cs_n,
  input  wire logic                                   sclk,
  input  wire logic                                   din,
  output logic                                        dout,
  output logic                                        dout_oe,
  input  wire logic                                   load_strobe_n,
  input  wire logic                                   wake_level_select,
  output logic      [CHANNELS-1:0][DAC_BITS-1:0]      dac_code,
  output logic      [CHANNELS-1:0]                    dac_buffer_on,
  output logic                                        dac_pull_to_ref,
  output logic      [dac_ctl_pkg::GPIO_BITS-1:0]      gpio_out,
  output logic                                        gpio_write,
  output logic      [1:0]                             clock_mode,
  output logic      [1:0]                             reference_select,
  output logic                                        osc_enable,
  output logic                                        conv_clock_tick,
  output logic                                        adc_ref_internal,
  output logic                                        adc_ref_second_pin,
  output logic                                        adc_ref_differential,
  output logic                                        dac_ref_external,
  output logic                                        second_pin_is_input,
  output logic                                        temp_start,
  output logic                                        temp_busy,
  input  wire logic                                   temp_done,
  input  wire logic [dac_ctl_pkg::TEMP_BITS-1:0]      temp_code,
  output logic                                        scan_start,
  output logic      [7:0]                             scan_cmd,
  input  wire logic [dac_ctl_pkg::WORD_BITS-1:0]      adc_word,
  output logic                                        adc_pop
);
  typedef enum logic [2:0] {
    ST_CMD,
    ST_DAC_HI,
    ST_DAC_LO,
    ST_GPIO,
    ST_SKIP
  } cmd_state_e;

  localparam int SEL_W = $clog2(CHANNELS);

  frame_if link ();

  cmd_state_e                             state;
  cmd_state_e                             next_state;
  logic       [7:0]                       dac_hi;
  logic       [7:0]                       setup_reg;
  logic                                   ld_s1;
  logic                                   ld_s2;
  logic                                   wk_s1;
  logic                                   wk_s2;
  logic                                   sclk_r1;
  logic                                   sclk_r2;
  logic                                   sclk_rq;
  logic       [dac_ctl_pkg::WORD_BITS-1:0] dac_word;
  logic                                   dac_commit;
  logic       [3:0]                       dac_op;
  logic                                   dac_wr;
  logic       [CHANNELS-1:0]              load_mask;
  logic       [CHANNELS-1:0][DAC_BITS-1:0] input_code;
  logic                                   scan_pending;
  logic       [dac_ctl_pkg::TEMP_BITS-1:0] temp_result;
  logic                                   temp_valid;
  logic       [dac_ctl_pkg::WORD_BITS-1:0] out_shift;
  logic       [3:0]                       out_cnt;
  logic                                   out_is_temp;
  logic                                   word_done;

  function automatic logic is_cmd_dac(input logic [7:0] b);
    return b[7:4] == dac_ctl_pkg::CMD_DAC;
  endfunction

  function automatic logic [dac_ctl_pkg::WORD_BITS-1:0] temp_word(input logic [dac_ctl_pkg::TEMP_BITS-1:0] t);
    return {dac_ctl_pkg::TEMP_PAD, t};
  endfunction

  serial_shifter u_shifter
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .cs_n_pin (cs_n),
    .sclk_pin (sclk),
    .din_pin  (din),
    .link     (link.src)
  );

  // Level pins are synchronised; no reset so the wake level is valid in reset
  always_ff @(posedge clk)
  begin
    ld_s1   <= load_strobe_n;
    ld_s2   <= ld_s1;
    wk_s1   <= wake_level_select;
    wk_s2   <= wk_s1;
    sclk_r1 <= sclk;
    sclk_r2 <= sclk_r1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sclk_rq <= 1'b0;
    else
      sclk_rq <= sclk_r2;
  end

  // Command byte sequencing
  always_comb
  begin
    next_state = state;
    if (!link.frame_active)
      next_state = ST_CMD;
    else if (link.byte_valid)
    begin
      case (state)
        ST_CMD:
        begin
          if (is_cmd_dac(link.rx_byte))
            next_state = ST_DAC_HI;
          else if (link.rx_byte == dac_ctl_pkg::CMD_GPIO_WR)
            next_state = ST_GPIO;
          else
            next_state = ST_CMD;
        end
        ST_DAC_HI: next_state = ST_DAC_LO;
        ST_DAC_LO: next_state = ST_CMD;
        ST_GPIO:   next_state = ST_CMD;
        default:   next_state = ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_CMD;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dac_hi <= '0;
    else if (link.byte_valid && state == ST_DAC_HI)
      dac_hi <= link.rx_byte;
  end

  // Nothing reaches the bank until the third byte has fully arrived
  assign dac_commit = link.byte_valid && state == ST_DAC_LO;
  assign dac_word   = {dac_hi, link.rx_byte};
  assign dac_op     = dac_word[dac_ctl_pkg::DAC_OP_MSB:dac_ctl_pkg::DAC_OP_LSB];
  assign dac_wr     = dac_commit && !dac_op[dac_ctl_pkg::DAC_OP_ALL];

  always_comb
  begin
    load_mask = '0;
    if (!ld_s2)
      load_mask = '1;
    if (dac_commit && dac_op[dac_ctl_pkg::DAC_OP_ALL])
      load_mask = '1;
    else if (dac_commit && dac_op[dac_ctl_pkg::DAC_OP_LOAD])
      load_mask[dac_op[SEL_W-1:0]] = 1'b1;
  end

  dac_bank #(
    .CHANNELS (CHANNELS),
    .BITS     (DAC_BITS)
  ) u_bank
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .wake_level  (wk_s2),
    .wr_en       (dac_wr),
    .wr_chan     (dac_op[SEL_W-1:0]),
    .wr_data     (dac_word[dac_ctl_pkg::DAC_DATA_MSB:dac_ctl_pkg::DAC_DATA_LSB]),
    .load_mask   (load_mask),
    .input_code  (input_code),
    .output_code (dac_code),
    .buffer_on   (dac_buffer_on)
  );

  // Pull direction while buffers are off follows the wake level
  assign dac_pull_to_ref = wk_s2;

  // Setup register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      setup_reg <= dac_ctl_pkg::SETUP_RESET;
    else if (link.byte_valid && state == ST_CMD && link.rx_byte[7:6] == dac_ctl_pkg::CMD_SETUP)
      setup_reg <= link.rx_byte;
  end

  assign clock_mode       = setup_reg[dac_ctl_pkg::SETUP_CLK_LSB +: 2];
  assign reference_select = setup_reg[dac_ctl_pkg::SETUP_REF_LSB +: 2];
  assign osc_enable       = clock_mode != dac_ctl_pkg::CLK_SCLK;
  // Conversion timing follows serial clock rising edges only in mode 11
  assign conv_clock_tick  = clock_mode == dac_ctl_pkg::CLK_SCLK && sclk_r2 && !sclk_rq;

  // Reference routing; a temperature run forces the internal reference
  always_comb
  begin
    adc_ref_internal     = 1'b0;
    adc_ref_second_pin   = 1'b0;
    adc_ref_differential = 1'b0;
    dac_ref_external     = 1'b0;
    case (reference_select)
      dac_ctl_pkg::REF_INT_BOTH:
        adc_ref_internal = 1'b1;
      dac_ctl_pkg::REF_ADC_INT:
      begin
        adc_ref_internal = 1'b1;
        dac_ref_external = 1'b1;
      end
      dac_ctl_pkg::REF_EXT_BOTH:
      begin
        dac_ref_external   = 1'b1;
        adc_ref_second_pin = 1'b1;
      end
      default:
        adc_ref_differential = 1'b1;
    endcase
    if (temp_busy)
    begin
      adc_ref_internal     = 1'b1;
      adc_ref_second_pin   = 1'b0;
      adc_ref_differential = 1'b0;
    end
  end

  assign second_pin_is_input = reference_select == dac_ctl_pkg::REF_INT_BOTH
                            || reference_select == dac_ctl_pkg::REF_ADC_INT;

  // GPIO write; variants without pins drop the data byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gpio_out   <= '0;
      gpio_write <= 1'b0;
    end
    else
    begin
      gpio_write <= 1'b0;
      if (HAS_GPIO && link.byte_valid && state == ST_GPIO)
      begin
        gpio_out   <= link.rx_byte[dac_ctl_pkg::GPIO_BITS-1:0];
        gpio_write <= 1'b1;
      end
    end
  end

  // Conversion command: temperature first, channel scan held until it ends
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      temp_start   <= 1'b0;
      temp_busy    <= 1'b0;
      scan_start   <= 1'b0;
      scan_pending <= 1'b0;
      scan_cmd     <= '0;
    end
    else
    begin
      temp_start <= 1'b0;
      scan_start <= 1'b0;
      if (link.byte_valid && state == ST_CMD && link.rx_byte[dac_ctl_pkg::CMD_CONV_BIT])
      begin
        scan_cmd <= link.rx_byte;
        if (link.rx_byte[dac_ctl_pkg::CMD_TEMP_BIT])
        begin
          temp_start   <= 1'b1;
          temp_busy    <= 1'b1;
          scan_pending <= 1'b1;
        end
        else
          scan_start <= 1'b1;
      end
      else if (temp_done && temp_busy)
      begin
        temp_busy    <= 1'b0;
        scan_pending <= 1'b0;
        scan_start   <= scan_pending;
      end
    end
  end

  // Unread result is replaced; a completion in the read-out cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      temp_result <= '0;
      temp_valid  <= 1'b0;
    end
    else if (temp_done)
    begin
      temp_result <= temp_code;
      temp_valid  <= 1'b1;
    end
    else if (word_done && out_is_temp)
      temp_valid <= 1'b0;
  end

  // Result read-out, MSB first, one bit per falling serial edge
  assign word_done = link.fall_tick && out_cnt == dac_ctl_pkg::OUT_LAST;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_shift   <= '0;
      out_cnt     <= '0;
      out_is_temp <= 1'b0;
      adc_pop     <= 1'b0;
    end
    else
    begin
      adc_pop <= 1'b0;
      if (link.frame_start || word_done)
      begin
        if (word_done && !out_is_temp)
          adc_pop <= 1'b1;
        out_cnt <= '0;
        if (temp_valid && !(word_done && out_is_temp))
        begin
          out_shift   <= temp_word(temp_result);
          out_is_temp <= 1'b1;
        end
        else
        begin
          out_shift   <= adc_word;
          out_is_temp <= 1'b0;
        end
      end
      else if (link.fall_tick)
      begin
        out_shift <= {out_shift[dac_ctl_pkg::WORD_BITS-2:0], 1'b0};
        out_cnt   <= out_cnt + 4'h1;
      end
    end
  end

  assign dout    = out_shift[dac_ctl_pkg::WORD_BITS-1];
  assign dout_oe = link.frame_active;
endmodule

// file: sim/dac_ctl_sva.sv
/*
  Concurrent checks on the control block's top-level ports.
  Assumes it is bound into the control block; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module dac_ctl_sva
#(
  parameter int CHANNELS = dac_ctl_pkg::DAC_CHANNELS,
  parameter int DAC_BITS = dac_ctl_pkg::DAC_BITS
)
(
  input wire logic                              clk,
  input wire logic                              rst_n,
  input wire logic                              wake_level_select,
  input wire logic [CHANNELS-1:0][DAC_BITS-1:0] dac_code,
  input wire logic                              dac_pull_to_ref,
  input wire logic [1:0]                        clock_mode,
  input wire logic [1:0]                        reference_select,
  input wire logic                              osc_enable,
  input wire logic                              conv_clock_tick,
  input wire logic                              adc_ref_internal,
  input wire logic                              adc_ref_second_pin,
  input wire logic                              adc_ref_differential,
  input wire logic                              dac_ref_external,
  input wire logic                              second_pin_is_input,
  input wire logic                              temp_start,
  input wire logic                              temp_busy,
  input wire logic                              temp_done,
  input wire logic                              scan_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  osc_mode_a:
    assert property (osc_enable == (clock_mode != 2'h3)) else $error("oscillator enable wrong for clock mode");
  tick_mode_a:
    assert property (conv_clock_tick |-> clock_mode == 2'h3) else $error("conversion tick outside mode 11");
  pin_role_a:
    assert property (second_pin_is_input == !reference_select[0]) else $error("second pin role wrong");
  dac_ref_a:
    assert property (reference_select != 2'h3 |-> dac_ref_external == (reference_select != 2'h0))
      else $error("DAC reference source wrong");
  int_ref_a:
    assert property (!reference_select[0] |-> adc_ref_internal) else $error("ADC not on internal reference");
  ext_ref_a:
    assert property (reference_select == 2'h1 && !temp_busy |-> adc_ref_second_pin && !adc_ref_internal)
      else $error("ADC not on second reference pin");
  diff_ref_a:
    assert property (reference_select == 2'h3 && !temp_busy |-> adc_ref_differential && !adc_ref_internal)
      else $error("ADC not on differential reference");
  temp_ref_a:
    assert property (temp_busy |-> adc_ref_internal && !adc_ref_second_pin && !adc_ref_differential)
      else $error("temperature run off internal reference");
  setup_reset_a:
    assert property ($rose(rst_n) |-> clock_mode == 2'h2 && reference_select == 2'h2)
      else $error("setup fields wrong after reset");
  wake_reset_a:
    assert property ($rose(rst_n) |-> dac_code == {CHANNELS{{DAC_BITS{wake_level_select}}}}
                     && dac_pull_to_ref == wake_level_select) else $error("wake codes wrong after reset");
  temp_first_a:
    assert property (temp_start |-> !scan_start ##1 (temp_busy && !scan_start))
      else $error("scan started ahead of temperature");
  scan_after_a:
    assert property (temp_busy && temp_done |=> scan_start) else $error("scan not started after temperature");
endmodule

// file: sim/spi_host_model.sv
/*
  Behavioural serial host: sends byte frames MSB first and captures dout.
  Assumes clk runs at least four times the serial clock it makes.
*/
`timescale 1ns/1ps
module spi_host_model
#(
  parameter int HALF = 4
)
(
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  logic [31:0] rx;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b1;
    rx   = '0;
  end

  // Serial clock stands low outside frames
  task automatic frame(input logic [7:0] b[$]);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    foreach (b[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        din = b[i][k];
        repeat (HALF) @(negedge clk);
        sclk = 1'b1;
        rx   = {rx[30:0], dout};
        repeat (HALF) @(negedge clk);
        sclk = 1'b0;
        // Hold well past the fall, the device samples late
        repeat (HALF) @(negedge clk);
      end
    end
    repeat (2 * HALF) @(negedge clk);
    cs_n = 1'b1;
    din  = ~din;
    repeat (2 * HALF) @(negedge clk);
  endtask
endmodule

// file: sim/dac_ref_temp_serial_control_test.sv
/*
  Self-checking bench: setup table, DAC writes and loads, cut frame, GPIO,
  temperature request and readout, wake levels at reset.
  Assumes the host model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
module dac_ref_temp_serial_control_test;
  typedef struct packed {logic [7:0] cmd; logic [1:0] cm; logic [1:0] rs;} row_s;
  localparam row_s ROWS [4] = '{'{8'h4c, 2'h0, 2'h3}, '{8'h74, 2'h3, 2'h1},
                                '{8'h50, 2'h1, 2'h0}, '{8'h68, 2'h2, 2'h2}};
  logic        clk, rst_n, cs_n, sclk, din, dout, dout_oe, load_strobe_n, wake_level_select;
  logic [dac_ctl_pkg::DAC_CHANNELS-1:0][dac_ctl_pkg::DAC_BITS-1:0] dac_code;
  logic [3:0]  dac_buffer_on, gpio_out;
  logic [1:0]  clock_mode, reference_select;
  logic        dac_pull_to_ref, gpio_write, osc_enable, conv_clock_tick, adc_ref_internal;
  logic        adc_ref_second_pin, adc_ref_differential, dac_ref_external, second_pin_is_input;
  logic        temp_start, temp_busy, temp_done, scan_start, adc_pop;
  logic [11:0] temp_code;
  logic [7:0]  scan_cmd;
  logic [15:0] adc_word;
  int          n_errors = 0;
  int          checks = 0;

  dac_ref_temp_serial_control dut_u (.clk, .rst_n, .cs_n, .sclk, .din, .dout, .dout_oe, .load_strobe_n,
    .wake_level_select, .dac_code, .dac_buffer_on, .dac_pull_to_ref, .gpio_out, .gpio_write, .clock_mode,
    .reference_select, .osc_enable, .conv_clock_tick, .adc_ref_internal, .adc_ref_second_pin,
    .adc_ref_differential, .dac_ref_external, .second_pin_is_input, .temp_start, .temp_busy, .temp_done,
    .temp_code, .scan_start, .scan_cmd, .adc_word, .adc_pop);
  spi_host_model host_u (.clk, .cs_n, .sclk, .din, .dout);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic wake);
    @(negedge clk);
    rst_n = 1'b0;
    wake_level_select = wake;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic dac_write(input logic [3:0] op, input logic [9:0] code);
    logic [15:0] w;
    w = {op, code, 2'b00};
    host_u.frame({8'h10, w[15:8], w[7:0]});
  endtask

  task automatic temp_result(input logic [11:0] t);
    check(temp_busy, 1'b1, "busy after request");
    @(negedge clk);
    temp_code = t;
    temp_done = 1'b1;
    @(negedge clk);
    temp_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial
  begin
    rst_n = 1'b0;
    load_strobe_n = 1'b1;
    wake_level_select = 1'b1;
    temp_done = 1'b0;
    temp_code = '0;
    adc_word = 16'h0a5c;
    do_reset(1'b1);
    check(dac_code, {4{10'h3ff}}, "wake high codes");
    check(dac_buffer_on, 4'h0, "buffers off");
    check({clock_mode, reference_select}, 4'ha, "setup after reset");
    $display("test reset finished");
    // Mode 11 row is not last, so frames after the following row make no conversion ticks
    foreach (ROWS[i])
    begin
      host_u.frame({ROWS[i].cmd});
      check({clock_mode, reference_select}, {ROWS[i].cm, ROWS[i].rs}, "setup fields");
      check(osc_enable, ROWS[i].cm != 2'h3, "oscillator");
      check(second_pin_is_input, !ROWS[i].rs[0], "second pin role");
    end
    $display("test setup table finished");
    dac_write(4'h1, 10'h2b7);
    check(dac_code[1], 10'h3ff, "held until load");
    @(negedge clk);
    load_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    load_strobe_n = 1'b1;
    repeat (4) @(negedge clk);
    check(dac_code, {10'h3ff, 10'h3ff, 10'h2b7, 10'h3ff}, "load strobe");
    dac_write(4'h6, 10'h155);
    check(dac_code[2], 10'h155, "write and load");
    host_u.frame({8'h10, 8'h40});
    check(dac_code[0], 10'h3ff, "cut frame");
    dac_write(4'h4, 10'h001);
    check(dac_code[0], 10'h001, "write after cut frame");
    $display("test dac finished");
    host_u.frame({8'h03, 8'h0a, 8'h03, 8'h05});
    check(gpio_out, 4'h5, "gpio back to back");
    $display("test gpio finished");
    host_u.frame({8'h81});
    temp_result(12'hf38);
    host_u.frame({8'h81});
    temp_result(12'h0c8);
    host_u.frame({8'h00, 8'h00, 8'h00, 8'h00});
    check(host_u.rx, {4'h0, 12'h0c8, 16'h0a5c}, "temperature then fifo");
    check({scan_cmd, dout_oe}, {8'h81, 1'b0}, "conversion byte kept, bus released");
    $display("test temperature finished");
    do_reset(1'b0);
    check(dac_code, '0, "wake low codes");
    check(dac_pull_to_ref, 1'b0, "pull to ground");
    $display("test wake low finished");
    final_report();
  end

  // Tests need under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule

bind dac_ref_temp_serial_control dac_ctl_sva #(.CHANNELS(CHANNELS), .DAC_BITS(DAC_BITS)) chk_u (.clk, .rst_n,
  .wake_level_select, .dac_code, .dac_pull_to_ref, .clock_mode, .reference_select, .osc_enable,
  .conv_clock_tick, .adc_ref_internal, .adc_ref_second_pin, .adc_ref_differential, .dac_ref_external,
  .second_pin_is_input, .temp_start, .temp_busy, .temp_done, .scan_start);
